// file: rtl/dbh_glue_end.sv
// processor-side glue: hold handover, buffer steering, waits, slave path
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - dma request synchronised, drives processor hold
// - processor finishes cycle, floats, then grants
// - float disables cpu buffers, grant enables dma buffers
// - dma address strobe starts wait generator
// - each dma wait lasts two clocks
// - request low returns bus to processor
// - top address pin held high during reset
// - select, strobes, 8-bit address, 16-bit data
// - status inputs held high in slave access
// - address and byte-high latched, bidirectional
// - decoded chip select for dma io range
// - read/write strobes delayed after chip select
// - ready held two clocks via extend pulse
module dbh_glue_end
  import dbh_pkg::*;
#(
  parameter int unsigned WAIT_STATES = 1,
  parameter logic [15:0] IO_BASE     = DMA_IO_BASE_RST,
  parameter logic [15:0] IO_MASK     = DMA_IO_MASK_RST
)
(
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 reset_in,
  // processor bus
  input  wire logic                 cpu_cycle_busy_in,
  input  wire logic                 cpu_io_req_in,
  input  wire logic                 cpu_write_in,
  input  wire logic [IO_ADDR_W-1:0] cpu_addr_in,
  input  wire logic                 cpu_bhe_n_in,
  input  wire logic [DATA_W-1:0]    cpu_wdata_in,
  output logic [DATA_W-1:0]         cpu_rdata_out,
  output logic                      cpu_ready_out,
  output logic                      cpu_floated_out,
  output logic                      cpu_buf_en_out,
  // link
  dbh_if.glue                       link
);
  dbh_state_t           st_ff, nxt_st;
  logic [2:0]           req_sync_ff;
  logic                 hold_ff, nxt_hold;
  logic                 grant_ff, nxt_grant;
  logic                 float_ff, nxt_float;
  logic                 cbuf_ff, nxt_cbuf;
  logic                 dbuf_ff, nxt_dbuf;
  logic                 half_ff;
  logic [3:0]           wcnt_ff, nxt_wcnt;
  logic                 async_ready_term;
  logic                 rpl_ff, nxt_rpl;
  logic                 rdy_ff, nxt_rdy;
  logic                 cs_n_ff, nxt_cs_n;
  logic                 rd_n_ff, nxt_rd_n;
  logic                 wr_n_ff, nxt_wr_n;
  logic [1:0]           dly_ff, nxt_dly;
  logic [ADDR_W-1:0]    addr_ff, nxt_addr;
  logic                 bhe_ff, nxt_bhe;
  logic [DATA_W-1:0]    wdat_ff, nxt_wdat;
  logic [DATA_W-1:0]    rdat_ff, nxt_rdat;
  logic                 strap_ff;
  logic                 dma_rst_ff;
  logic                 sel_hit;

  assign sel_hit = cpu_io_req_in & ((cpu_addr_in & IO_MASK) == IO_BASE);
  assign async_ready_term    = (wcnt_ff == 4'(WAIT_STATES * DMA_WAIT_CLKS)) & half_ff;

  always_comb
  begin
    nxt_st    = st_ff;
    nxt_hold  = req_sync_ff[2] & req_sync_ff[1];
    nxt_grant = grant_ff;
    nxt_float = float_ff;
    nxt_cbuf  = cbuf_ff;
    nxt_dbuf  = dbuf_ff;
    nxt_cs_n  = 1'b1;
    nxt_rd_n  = 1'b1;
    nxt_wr_n  = 1'b1;
    nxt_dly   = 2'b00;
    nxt_addr  = addr_ff;
    nxt_bhe   = bhe_ff;
    nxt_wdat  = wdat_ff;
    nxt_rdat  = rdat_ff;
    case (st_ff)
      DBH_ST_CPU:
      begin
        if (hold_ff & ~cpu_cycle_busy_in)
        begin
          nxt_float = 1'b1;
          nxt_cbuf  = 1'b0;
          nxt_st    = DBH_ST_TO_DMA;
        end
        else if (sel_hit)
        begin
          nxt_addr = cpu_addr_in[ADDR_W-1:0];
          nxt_bhe  = cpu_bhe_n_in;
          nxt_wdat = cpu_wdata_in;
          nxt_cs_n = 1'b0;
          nxt_st   = DBH_ST_SLAVE;
        end
      end
      DBH_ST_TO_DMA:
      begin
        nxt_grant = 1'b1;
        nxt_dbuf  = 1'b1;
        nxt_st    = DBH_ST_DMA;
      end
      DBH_ST_DMA:
      begin
        if (~hold_ff)
        begin
          nxt_dbuf = 1'b0;
          nxt_st   = DBH_ST_TO_CPU;
        end
      end
      DBH_ST_TO_CPU:
      begin
        nxt_grant = 1'b0;
        nxt_float = 1'b0;
        nxt_cbuf  = 1'b1;
        nxt_st    = DBH_ST_CPU;
      end
      DBH_ST_SLAVE:
      begin
        nxt_cs_n = 1'b0;
        nxt_dly  = (dly_ff == 2'(CMD_DELAY_CLKS)) ? dly_ff : dly_ff + 2'b01;
        if (dly_ff == 2'(CMD_DELAY_CLKS))
        begin
          nxt_rd_n = cpu_write_in;
          nxt_wr_n = ~cpu_write_in;
        end
        if (link.data_from_dma_oe)
        begin
          nxt_rdat = link.data_from_dma;
        end
        if (rdy_ff & ~rpl_ff)
        begin
          nxt_cs_n = 1'b1;
          nxt_rd_n = 1'b1;
          nxt_wr_n = 1'b1;
          nxt_st   = DBH_ST_CPU;
        end
      end
      default:
      begin
        nxt_st = DBH_ST_CPU;
      end
    endcase
  end

  always_comb
  begin
    nxt_wcnt = 4'h0;
    // start once per strobe, not on every low cycle, so the count can advance
    if (link.dma_ale | (st_ff == DBH_ST_SLAVE & dly_ff == 2'(CMD_DELAY_CLKS) & rd_n_ff & wr_n_ff))
    begin
      nxt_wcnt = 4'h1;
    end
    else if (wcnt_ff != 4'h0 & ~async_ready_term)
    begin
      // hold at the target until the half-rate phase lines up
      nxt_wcnt = (wcnt_ff == 4'(WAIT_STATES * DMA_WAIT_CLKS)) ? wcnt_ff : wcnt_ff + 4'h1;
    end
    nxt_rpl = async_ready_term;
    nxt_rdy = async_ready_term | rpl_ff;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      st_ff       <= DBH_ST_CPU;
      req_sync_ff <= 3'b000;
      hold_ff     <= 1'b0;
      grant_ff    <= 1'b0;
      float_ff    <= 1'b0;
      cbuf_ff     <= 1'b1;
      dbuf_ff     <= 1'b0;
      half_ff     <= 1'b0;
      wcnt_ff     <= 4'h0;
      rpl_ff      <= 1'b0;
      rdy_ff      <= 1'b0;
      cs_n_ff     <= 1'b1;
      rd_n_ff     <= 1'b1;
      wr_n_ff     <= 1'b1;
      dly_ff      <= 2'b00;
      addr_ff     <= 8'h00;
      bhe_ff      <= 1'b1;
      wdat_ff     <= 16'h0000;
      rdat_ff     <= 16'h0000;
      strap_ff    <= 1'b1;
      dma_rst_ff  <= 1'b1;
    end
    else
    begin
      st_ff       <= nxt_st;
      req_sync_ff <= {req_sync_ff[1:0], link.dma_hold_request};
      hold_ff     <= nxt_hold;
      grant_ff    <= nxt_grant;
      float_ff    <= nxt_float;
      cbuf_ff     <= nxt_cbuf;
      dbuf_ff     <= nxt_dbuf;
      half_ff     <= ~half_ff;
      wcnt_ff     <= nxt_wcnt;
      rpl_ff      <= nxt_rpl;
      rdy_ff      <= nxt_rdy;
      cs_n_ff     <= nxt_cs_n;
      rd_n_ff     <= nxt_rd_n;
      wr_n_ff     <= nxt_wr_n;
      dly_ff      <= nxt_dly;
      addr_ff     <= nxt_addr;
      bhe_ff      <= nxt_bhe;
      wdat_ff     <= nxt_wdat;
      rdat_ff     <= nxt_rdat;
      strap_ff    <= 1'b1;
      dma_rst_ff  <= 1'b0;
    end
  end

  assign link.cpu_hold_request_sync = hold_ff;
  assign link.hold_grant            = grant_ff;
  assign link.cpu_buf_en            = cbuf_ff;
  assign link.dma_buf_en            = dbuf_ff;
  assign link.dma_ready             = rdy_ff;
  assign link.dma_chip_select_n     = cs_n_ff;
  assign link.dma_rd_n              = rd_n_ff;
  assign link.dma_wr_n              = wr_n_ff;
  assign link.bus_status0_n         = 1'b1;
  assign link.bus_status1_n         = 1'b1;
  assign link.reg_addr              = addr_ff;
  assign link.reg_addr_oe           = cbuf_ff;
  assign link.byte_high_enable_n    = bhe_ff;
  assign link.data_to_dma           = wdat_ff;
  assign link.data_to_dma_oe        = ~cs_n_ff;
  assign link.mode_strap_pin        = strap_ff;
  assign link.dma_reset             = dma_rst_ff;
  assign cpu_rdata_out              = rdat_ff;
  assign cpu_ready_out              = rdy_ff;
  assign cpu_floated_out            = float_ff;
  assign cpu_buf_en_out             = cbuf_ff;
endmodule : dbh_glue_end
`default_nettype wire

// file: rtl/dbh_pkg.sv
// package: shared constants and types for the dma bus handover glue
package dbh_pkg;
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned DMA_WAIT_CLKS     = 2;
  localparam int unsigned READY_HOLD_CLKS   = 2;
  localparam int unsigned CMD_DELAY_CLKS    = 2;
  localparam int unsigned ADDR_W            = 8;
  localparam int unsigned DATA_W            = 16;
  localparam int unsigned IO_ADDR_W         = 16;
  localparam logic [15:0] DMA_IO_BASE_RST   = 16'h0100;
  localparam logic [15:0] DMA_IO_MASK_RST   = 16'hff00;

  typedef enum logic [4:0]
  {
    DBH_ST_CPU      = 5'b0_0001,
    DBH_ST_TO_DMA   = 5'b0_0010,
    DBH_ST_DMA      = 5'b0_0100,
    DBH_ST_TO_CPU   = 5'b0_1000,
    DBH_ST_SLAVE    = 5'b1_0000
  } dbh_state_t;
endpackage : dbh_pkg

// file: rtl/dbh_if.sv
// interface: link between processor-side glue and dma-side glue
`timescale 1ns/100ps
`default_nettype none
interface dbh_if;
  logic        dma_hold_request;
  logic        cpu_hold_request_sync;
  logic        hold_grant;
  logic        cpu_buf_en;
  logic        dma_buf_en;
  logic        dma_ale;
  logic        dma_ready;
  logic        dma_chip_select_n;
  logic        dma_rd_n;
  logic        dma_wr_n;
  logic        bus_status0_n;
  logic        bus_status1_n;
  logic [7:0]  reg_addr;
  logic        reg_addr_oe;
  logic        byte_high_enable_n;
  logic [15:0] data_to_dma;
  logic        data_to_dma_oe;
  logic [15:0] data_from_dma;
  logic        data_from_dma_oe;
  logic        mode_strap_pin;
  logic        dma_reset;

  modport glue
  (
    input  dma_hold_request, dma_ale, data_from_dma, data_from_dma_oe,
    output cpu_hold_request_sync, hold_grant, cpu_buf_en, dma_buf_en, dma_ready,
    output dma_chip_select_n, dma_rd_n, dma_wr_n, bus_status0_n, bus_status1_n,
    output reg_addr, reg_addr_oe, byte_high_enable_n, data_to_dma, data_to_dma_oe,
    output mode_strap_pin, dma_reset
  );
  modport dma
  (
    output dma_hold_request, dma_ale, data_from_dma, data_from_dma_oe,
    input  cpu_hold_request_sync, hold_grant, cpu_buf_en, dma_buf_en, dma_ready,
    input  dma_chip_select_n, dma_rd_n, dma_wr_n, bus_status0_n, bus_status1_n,
    input  reg_addr, reg_addr_oe, byte_high_enable_n, data_to_dma, data_to_dma_oe,
    input  mode_strap_pin, dma_reset
  );
endinterface : dbh_if
`default_nettype wire

// file: rtl/dbh_dma_end.sv
// dma controller end: bus request, strap sampling, slave register file
`timescale 1ns/100ps
`default_nettype none
module dbh_dma_end
  import dbh_pkg::*;
(
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               reset_in,
  // user side
  input  wire logic               xfer_req_in,
  output logic                    xfer_active_out,
  output logic                    compat_mode_out,
  output logic [DATA_W-1:0]       mode_reg_out,
  // link
  dbh_if.dma                      link
);
  logic               req_ff,    nxt_req;
  logic               act_ff,    nxt_act;
  logic               mode_ff,   nxt_mode;
  logic               ale_ff,    nxt_ale;
  logic [DATA_W-1:0]  regs_ff [0:3];
  logic [DATA_W-1:0]  rdat_ff,   nxt_rdat;
  logic               roe_ff,    nxt_roe;
  logic               wr_d_ff;
  logic               rst_d_ff;

  always_comb
  begin
    nxt_req  = xfer_req_in;
    nxt_act  = link.hold_grant & link.dma_buf_en & req_ff;
    nxt_ale  = nxt_act & ~act_ff;
    nxt_mode = mode_ff;
    if (rst_d_ff & ~link.dma_reset)
    begin
      nxt_mode = link.mode_strap_pin;
    end
    nxt_roe  = ~link.dma_chip_select_n & ~link.dma_rd_n
             & link.bus_status0_n & link.bus_status1_n;
    nxt_rdat = regs_ff[link.reg_addr[2:1]];
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      req_ff   <= 1'b0;
      act_ff   <= 1'b0;
      mode_ff  <= 1'b0;
      ale_ff   <= 1'b0;
      rdat_ff  <= 16'h0000;
      roe_ff   <= 1'b0;
      wr_d_ff  <= 1'b1;
      rst_d_ff <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
        regs_ff[i] <= 16'h0000;
      end
    end
    else
    begin
      req_ff   <= nxt_req;
      act_ff   <= nxt_act;
      mode_ff  <= nxt_mode;
      ale_ff   <= nxt_ale;
      rdat_ff  <= nxt_rdat;
      roe_ff   <= nxt_roe;
      wr_d_ff  <= link.dma_wr_n;
      rst_d_ff <= link.dma_reset;
      // take data as the write strobe falls; select is gone when it rises
      if (~link.dma_chip_select_n & ~link.dma_wr_n & wr_d_ff)
      begin
        regs_ff[link.reg_addr[2:1]] <= link.data_to_dma;
      end
    end
  end

  assign link.dma_hold_request = req_ff;
  assign link.dma_ale          = ale_ff;
  assign link.data_from_dma    = rdat_ff;
  assign link.data_from_dma_oe = roe_ff;
  assign xfer_active_out       = act_ff;
  assign compat_mode_out       = mode_ff;
  assign mode_reg_out          = regs_ff[0];
endmodule : dbh_dma_end
`default_nettype wire

// file: dv/dbh_props.sv
// checker: link-level properties of the dma bus handover glue
`timescale 1ns/100ps
`default_nettype none
module dbh_props
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // link signals
  input  wire logic       dma_hold_request,
  input  wire logic       cpu_hold_request_sync,
  input  wire logic       hold_grant,
  input  wire logic       cpu_buf_en,
  input  wire logic       dma_buf_en,
  input  wire logic       dma_ale,
  input  wire logic       dma_ready,
  input  wire logic       dma_chip_select_n,
  input  wire logic       dma_rd_n,
  input  wire logic       dma_wr_n,
  input  wire logic       bus_status0_n,
  input  wire logic       bus_status1_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       byte_high_enable_n,
  input  wire logic       mode_strap_pin,
  input  wire logic       dma_reset
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_sync_delay: assert property ($rose(dma_hold_request) |->
    !cpu_hold_request_sync [*2] ##[1:3] cpu_hold_request_sync)
    else $error("hold sync latency wrong");
  a_grant_after_float: assert property ($rose(hold_grant) |-> cpu_hold_request_sync && !$past(cpu_buf_en))
    else $error("grant without request or dead cycle");
  a_float_then_grant: assert property ($fell(cpu_buf_en) |=> hold_grant && dma_buf_en)
    else $error("dma side not enabled after cpu side off");
  a_dma_buf_owned: assert property (dma_buf_en |-> hold_grant && !cpu_buf_en)
    else $error("dma buffers on without grant");
  a_buf_exclusive: assert property (!(cpu_buf_en && dma_buf_en))
    else $error("both buffer sides enabled");
  a_release_order: assert property ($fell(dma_buf_en) |=> !hold_grant && cpu_buf_en)
    else $error("bus not returned after dma buffers off");
  a_release_bound: assert property ($fell(dma_hold_request) |-> ##[1:8] !dma_buf_en)
    else $error("dma buffers not released");
  a_ale_start: assert property ($rose(hold_grant) |-> ##[1:3] dma_ale)
    else $error("no address strobe after grant");
  a_ale_owned: assert property (dma_ale |-> hold_grant && dma_buf_en)
    else $error("address strobe outside dma ownership");
  a_status_high: assert property (bus_status0_n && bus_status1_n)
    else $error("status inputs not held high");
  a_strap_reset: assert property (dma_reset |-> mode_strap_pin)
    else $error("mode strap low during dma reset");
  a_cs_cpu_owned: assert property (!dma_chip_select_n |-> cpu_buf_en && !hold_grant)
    else $error("chip select while dma owns bus");
  a_cmd_delay: assert property ($fell(dma_chip_select_n) |-> (dma_rd_n && dma_wr_n) [*2])
    else $error("command too soon after chip select");
  a_cmd_in_cs: assert property (!(dma_rd_n && dma_wr_n) |-> !dma_chip_select_n && (dma_rd_n || dma_wr_n))
    else $error("command outside select or both strobes low");
  a_addr_held: assert property (!dma_chip_select_n && !$past(dma_chip_select_n) |->
    $stable(reg_addr) && $stable(byte_high_enable_n))
    else $error("latched address moved during select");
  a_wait_two: assert property ($fell(dma_rd_n && dma_wr_n) |-> !dma_ready [*2])
    else $error("ready before wait states elapsed");
  a_ready_two: assert property ($rose(dma_ready) |=> dma_ready ##1 !dma_ready)
    else $error("ready not two cycles");

  c_grant: cover property ($rose(hold_grant));
  c_write: cover property ($rose(dma_ready) && !dma_wr_n);
  c_read: cover property ($rose(dma_ready) && !dma_rd_n);
endmodule : dbh_props
`default_nettype wire

// file: dv/tb.sv
// testbench: both ends of the dma bus handover glue joined by their link
`timescale 1ns/100ps
`default_nettype none
module tb
  import dbh_pkg::*;
;
  logic                 clk_in;
  logic                 reset_in;
  logic                 cpu_cycle_busy_in;
  logic                 cpu_io_req_in;
  logic                 cpu_write_in;
  logic [IO_ADDR_W-1:0] cpu_addr_in;
  logic                 cpu_bhe_n_in;
  logic [DATA_W-1:0]    cpu_wdata_in;
  logic [DATA_W-1:0]    cpu_rdata_out;
  logic                 cpu_ready_out;
  logic                 cpu_floated_out;
  logic                 cpu_buf_en_out;
  logic                 xfer_req_in;
  logic                 xfer_active_out;
  logic                 compat_mode_out;
  logic [DATA_W-1:0]    mode_reg_out;
  int                   err_count;
  int                   num_checks;
  int                   n;

  dbh_if link_if();
  dbh_glue_end dbh_glue_end_inst
  (
    .clk_in(clk_in), .reset_in(reset_in), .cpu_cycle_busy_in(cpu_cycle_busy_in),
    .cpu_io_req_in(cpu_io_req_in), .cpu_write_in(cpu_write_in), .cpu_addr_in(cpu_addr_in),
    .cpu_bhe_n_in(cpu_bhe_n_in), .cpu_wdata_in(cpu_wdata_in), .cpu_rdata_out(cpu_rdata_out),
    .cpu_ready_out(cpu_ready_out), .cpu_floated_out(cpu_floated_out), .cpu_buf_en_out(cpu_buf_en_out),
    .link(link_if.glue)
  );
  dbh_dma_end dbh_dma_end_inst
  (
    .clk_in(clk_in), .reset_in(reset_in), .xfer_req_in(xfer_req_in), .xfer_active_out(xfer_active_out),
    .compat_mode_out(compat_mode_out), .mode_reg_out(mode_reg_out), .link(link_if.dma)
  );
  dbh_props dbh_props_inst
  (
    .clk_in(clk_in), .reset_in(reset_in), .dma_hold_request(link_if.dma_hold_request),
    .cpu_hold_request_sync(link_if.cpu_hold_request_sync), .hold_grant(link_if.hold_grant),
    .cpu_buf_en(link_if.cpu_buf_en), .dma_buf_en(link_if.dma_buf_en), .dma_ale(link_if.dma_ale),
    .dma_ready(link_if.dma_ready), .dma_chip_select_n(link_if.dma_chip_select_n),
    .dma_rd_n(link_if.dma_rd_n), .dma_wr_n(link_if.dma_wr_n), .bus_status0_n(link_if.bus_status0_n),
    .bus_status1_n(link_if.bus_status1_n), .reg_addr(link_if.reg_addr),
    .byte_high_enable_n(link_if.byte_high_enable_n), .mode_strap_pin(link_if.mode_strap_pin),
    .dma_reset(link_if.dma_reset)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic check_bit(input logic seen, input logic exp);
    check({15'h0000, seen}, {15'h0000, exp});
  endtask : check_bit

  task automatic bound_hit(input int cnt, input int lim);
    if (cnt >= lim)
    begin
      err_count++;
      $display("Error at %0t: wait ran out", $time);
      close_out();
    end
  endtask : bound_hit

  // one slave access, held until ready
  task automatic io_access(input logic wr, input logic [15:0] addr, input logic [15:0] data);
    cpu_write_in = wr;
    cpu_addr_in = addr;
    cpu_wdata_in = data;
    cpu_io_req_in = 1'b1;
    for (n = 0; n < 20 && link_if.dma_chip_select_n !== 1'b0; n++) @(negedge clk_in);
    bound_hit(n, 20);
    check({8'h00, link_if.reg_addr}, {8'h00, addr[7:0]});
    check_bit(link_if.byte_high_enable_n, 1'b0);
    for (n = 0; n < 40 && cpu_ready_out !== 1'b1; n++) @(negedge clk_in);
    bound_hit(n, 40);
    check_bit(link_if.dma_wr_n, !wr);
    check_bit(link_if.dma_rd_n, wr);
    if (!wr)
      check(cpu_rdata_out, data);
    cpu_io_req_in = 1'b0;
    @(negedge clk_in);
    check_bit(cpu_ready_out, 1'b1);
    @(negedge clk_in);
    check_bit(cpu_ready_out, 1'b0);
  endtask : io_access

  // access that must never raise chip select
  task automatic io_refused(input logic [15:0] addr);
    int lows;
    lows = 0;
    cpu_write_in = 1'b1;
    cpu_addr_in = addr;
    cpu_io_req_in = 1'b1;
    repeat (20)
    begin
      @(negedge clk_in);
      lows += (link_if.dma_chip_select_n === 1'b0);
    end
    cpu_io_req_in = 1'b0;
    check(lows[15:0], 16'h0000);
  endtask : io_refused

  initial
  begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    $display("Error at %0t: run limit reached", $time);
    close_out();
  end

  initial
  begin
    err_count = 0;
    num_checks = 0;
    reset_in = 1'b1;
    cpu_cycle_busy_in = 1'b0;
    cpu_io_req_in = 1'b0;
    cpu_write_in = 1'b0;
    cpu_addr_in = 16'h0000;
    cpu_bhe_n_in = 1'b0;
    cpu_wdata_in = 16'h0000;
    xfer_req_in = 1'b0;
    repeat (20) @(negedge clk_in);
    reset_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check_bit(cpu_buf_en_out, 1'b1);
    check_bit(link_if.dma_buf_en, 1'b0);
    check_bit(compat_mode_out, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
      io_access(1'b1, DMA_IO_BASE_RST + 16'(2 * i), 16'hc3a0 + 16'(i));
    for (int i = 3; i >= 0; i--)
      io_access(1'b0, DMA_IO_BASE_RST + 16'(2 * i), 16'hc3a0 + 16'(i));
    check(mode_reg_out, 16'hc3a0);
    io_refused(16'h0200);
    $display("test slave done");
    cpu_cycle_busy_in = 1'b1;
    xfer_req_in = 1'b1;
    for (n = 0; n < 30 && link_if.cpu_hold_request_sync !== 1'b1; n++) @(negedge clk_in);
    bound_hit(n, 30);
    check_bit(n >= 3, 1'b1);
    repeat (10) @(negedge clk_in);
    check_bit(link_if.hold_grant, 1'b0);
    check_bit(cpu_buf_en_out, 1'b1);
    cpu_cycle_busy_in = 1'b0;
    for (n = 0; n < 10 && link_if.hold_grant !== 1'b1; n++) @(negedge clk_in);
    bound_hit(n, 10);
    check_bit(cpu_floated_out, 1'b1);
    check_bit(cpu_buf_en_out, 1'b0);
    check_bit(link_if.dma_buf_en, 1'b1);
    repeat (3) @(negedge clk_in);
    check_bit(xfer_active_out, 1'b1);
    io_refused(DMA_IO_BASE_RST);
    xfer_req_in = 1'b0;
    for (n = 0; n < 20 && cpu_buf_en_out !== 1'b1; n++) @(negedge clk_in);
    bound_hit(n, 20);
    check_bit(link_if.hold_grant, 1'b0);
    check_bit(link_if.dma_buf_en, 1'b0);
    repeat (3) @(negedge clk_in);
    check_bit(xfer_active_out, 1'b0);
    check_bit(cpu_floated_out, 1'b0);
    io_access(1'b0, DMA_IO_BASE_RST, 16'hc3a0);
    $display("test handover done");
    close_out();
  end
endmodule : tb
`default_nettype wire
